//--- common/timer_pkg.sv
// Constants shared by the gated wide timer, the period timer and their helpers.
// Assumes one system clock; instruction clock is an enable every fourth cycle.
// What this block does
// RULE1: Clock source code picks wide count clock
// RULE2: Source 10 uses pin or oscillator edge
// RULE3: Wide prescaler divides by 1, 2, 4, 8
// RULE4: Sync control chooses path for external source
// RULE5: Run bit enables; clearing clears toggle flip-flop
// RULE6: Gate enable matters only while running
// RULE7: Polarity bit picks active gate level
// RULE8: Toggle mode flip-flop toggles on source rise
// RULE9: Single-pulse bit enables single-pulse gate acquisition
// RULE10: Armed bit set by software, hardware clears
// RULE11: Gate value bit readable, independent of enable
// RULE12: Gate source: pin, overflow, period match
// RULE13: Period timer counts instruction clock from zero
// RULE14: Period prescaler divides by 1, 4, 16, 64
// RULE15: Match pulses, restarts count, clocks postscaler
// RULE16: Reset clears count, period limit becomes FFh
// RULE17: Count or control write clears scalers
// RULE18: Control write leaves period count unchanged
// RULE19: Postscaler sets flag; request needs enable
// RULE20: Unscaled match pulse exported for PWM, serial
// RULE21: Period timer holds still during sleep
// RULE22: Period control layout: postscale, run, prescale
// RULE23: Single pulse opens on edge, trailing clears
// RULE24: Gate falling sets event; rollover sets overflow
// RULE25: Overflow and match reach gate as pulses
// RULE26: Wide count increments on gated prescaled tick
package timer_pkg;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;

    // Register map, one byte each
    localparam logic [3:0] OFS_WIDE_CTRL   = 4'h0;
    localparam logic [3:0] OFS_GATE_CTRL   = 4'h1;
    localparam logic [3:0] OFS_WIDE_LOW    = 4'h2;
    localparam logic [3:0] OFS_WIDE_HIGH   = 4'h3;
    localparam logic [3:0] OFS_PERIOD_CNT  = 4'h4;
    localparam logic [3:0] OFS_PERIOD_LIM  = 4'h5;
    localparam logic [3:0] OFS_PERIOD_CTRL = 4'h6;
    localparam logic [3:0] OFS_FLAGS       = 4'h7;
    localparam logic [3:0] OFS_IRQ_EN      = 4'h8;

    // Writable bit masks; unimplemented bits read zero
    localparam logic [7:0] WIDE_CTRL_MASK   = 8'hFD;
    localparam logic [7:0] GATE_CTRL_MASK   = 8'hF3;
    localparam logic [7:0] PERIOD_CTRL_MASK = 8'h7F;

    // Wide timer control fields
    localparam int unsigned WC_CS_HI   = 7;
    localparam int unsigned WC_CS_LO   = 6;
    localparam int unsigned WC_PS_HI   = 5;
    localparam int unsigned WC_PS_LO   = 4;
    localparam int unsigned WC_OSCEN   = 3;
    localparam int unsigned WC_BYPASS  = 2;
    localparam int unsigned WC_RUN     = 0;

    // Gate control fields
    localparam int unsigned GC_ENABLE  = 7;
    localparam int unsigned GC_POL     = 6;
    localparam int unsigned GC_TOGGLE  = 5;
    localparam int unsigned GC_SPM     = 4;
    localparam int unsigned GC_ARMED   = 3;
    localparam int unsigned GC_VALUE   = 2;
    localparam int unsigned GC_SS_HI   = 1;
    localparam int unsigned GC_SS_LO   = 0;

    // Period control fields
    localparam int unsigned PC_POST_HI = 6;
    localparam int unsigned PC_POST_LO = 3;
    localparam int unsigned PC_RUN     = 2;
    localparam int unsigned PC_PRE_HI  = 1;
    localparam int unsigned PC_PRE_LO  = 0;

    // Flag and enable bits
    localparam int unsigned FL_WIDE_OVF = 0;
    localparam int unsigned FL_PERIOD   = 1;
    localparam int unsigned FL_GATE_EVT = 7;

    // Reset values
    localparam logic [7:0]  RST_BYTE       = 8'h00;
    localparam logic [7:0]  RST_PERIOD_LIM = 8'hFF;
    localparam logic [15:0] RST_WIDE       = 16'h0000;
    localparam logic [1:0]  QUARTER_LAST   = 2'h3;

    typedef enum logic [1:0] {
        SRC_INSTR,
        SRC_SYSTEM,
        SRC_EXTERNAL,
        SRC_LFOSC
    } wide_src_t;

    typedef enum logic [1:0] {
        GATE_PIN,
        GATE_OVF8,
        GATE_MATCH,
        GATE_RESERVED
    } gate_src_t;

    typedef enum logic [1:0] {
        SP_IDLE,
        SP_WAIT_LEAD,
        SP_OPEN
    } sp_state_t;

    // Prescale limits (count modulus minus one)
    localparam logic [2:0] WPS_DIV1 = 3'h0;
    localparam logic [2:0] WPS_DIV2 = 3'h1;
    localparam logic [2:0] WPS_DIV4 = 3'h3;
    localparam logic [2:0] WPS_DIV8 = 3'h7;
    localparam logic [5:0] PPS_DIV1  = 6'h00;
    localparam logic [5:0] PPS_DIV4  = 6'h03;
    localparam logic [5:0] PPS_DIV16 = 6'h0F;
    localparam logic [5:0] PPS_DIV64 = 6'h3F;
endpackage

//--- common/tick_div_if.sv
// Connection between a tick owner and a divider counter.
// Assumes owner and divider share one clock.
`timescale 1ns/10ps
`default_nettype none
interface tick_div_if #(parameter int unsigned W = 4);
    logic         tick;
    logic         clear;
    logic [W-1:0] limit;
    logic         pulse;

    modport owner   (output tick, output clear, output limit, input pulse);
    modport divider (input tick, input clear, input limit, output pulse);
endinterface
`default_nettype wire

//--- rtl/tick_divider.sv
// Divide-by-(limit+1) counter for prescalers and postscaler.
// Assumes tick is a one-cycle enable in the clk_sys_i domain.
`timescale 1ns/10ps
`default_nettype none
module tick_divider
    import timer_pkg::*;
#(
    parameter int unsigned W = 4
)(
    input  wire logic      clk_sys_i,
    input  wire logic      nrst_i,
    input  wire logic      clk_en_i,
    tick_div_if.divider    div
);
    logic [W-1:0] cnt_q;

    // Pulse on the tick that completes a full ratio
    assign div.pulse = div.tick && (cnt_q == div.limit);

    // Clear wins over tick so a rewrite restarts the ratio
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            cnt_q <= '0;
        else if (clk_en_i)
        begin
            if (div.clear)
                cnt_q <= '0;
            else if (div.pulse)
                cnt_q <= '0;
            else if (div.tick)
                cnt_q <= cnt_q + W'(1);
        end
    end
endmodule
`default_nettype wire

//--- rtl/edge_sync.sv
// Two-flop synchroniser for a pin level with a rising-edge pulse.
// Assumes pin_i is asynchronous to clk_sys_i.
`timescale 1ns/10ps
`default_nettype none
module edge_sync (
    input  wire logic clk_sys_i,
    input  wire logic nrst_i,
    input  wire logic clk_en_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // Only sync_q reads meta_q; edge detect works on safe stages
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_o = sync_q;
    assign rise_o  = sync_q && !prev_q;
endmodule
`default_nettype wire

//--- rtl/gated_timer.sv
// Gated 16-bit wide timer and 8-bit period timer with register port.
// Assumes clk_sys_i is the system clock; pins are asynchronous to it.
`timescale 1ns/10ps
`default_nettype none
module gated_timer
    import timer_pkg::*;
(
    input  wire logic              clk_sys_i,
    input  wire logic              nrst_i,
    input  wire logic              clk_en_i,
    input  wire logic              sleep_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rdata_o,
    input  wire logic              wide_ext_clock_pin_i,
    input  wire logic              secondary_osc_in_i,
    input  wire logic              low_freq_internal_osc_i,
    input  wire logic              gate_input_pin_i,
    input  wire logic              overflow8_pulse_i,
    output logic                   period_match_o,
    output logic                   wide_overflow_flag_o,
    output logic                   gate_event_flag_o,
    output logic                   period_match_flag_o,
    output logic                   period_irq_req_o
);
    // Register state
    logic [7:0]  wctl_q;
    logic [7:0]  gctl_q;
    logic        armed_q;
    logic        gval_q;
    logic [15:0] wide_q;
    logic [7:0]  pcnt_q;
    logic [7:0]  plim_q;
    logic [7:0]  pctl_q;
    logic        wovf_q;
    logic        gevt_q;
    logic        pflag_q;
    logic        irq_en_q;
    logic [1:0]  quarter_q;
    logic        ext_resync_q;
    logic        tff_q;
    logic        gsrc_prev_q;
    logic        gact_prev_q;
    sp_state_t   sp_q;
    logic [7:0]  rdata_q;

    // Decoded fields and internal nets
    wide_src_t   wsrc;
    gate_src_t   gsrc_sel;
    logic        wide_run;
    logic        instr_tick;
    logic        src_tick;
    logic        ext_edge;
    logic        ext_tick;
    logic        gate_src;
    logic        gate_sig;
    logic        gate_active;
    logic        gate_val;
    logic        count_en;
    logic        wide_tick;
    logic        period_tick;
    logic        match;
    logic        pin_clk_rise;
    logic        osc_rise;
    logic        lfosc_rise;
    logic        gate_pin_lvl;
    logic        wr_wctl;
    logic        wr_gctl;
    logic        wr_low;
    logic        wr_high;
    logic        wr_pcnt;
    logic        wr_plim;
    logic        wr_pctl;
    logic        wr_flags;
    logic        wr_irq_en;
    logic        sp_trail;

    tick_div_if #(.W(3)) wide_pre ();
    tick_div_if #(.W(6)) per_pre ();
    tick_div_if #(.W(4)) per_post ();

    // Pin inputs, each through its own synchroniser
    edge_sync u_pin_clk (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .clk_en_i  (clk_en_i),
        .pin_i     (wide_ext_clock_pin_i),
        .level_o   (),
        .rise_o    (pin_clk_rise)
    );
    edge_sync u_osc (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .clk_en_i  (clk_en_i),
        .pin_i     (secondary_osc_in_i),
        .level_o   (),
        .rise_o    (osc_rise)
    );
    edge_sync u_lfosc (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .clk_en_i  (clk_en_i),
        .pin_i     (low_freq_internal_osc_i),
        .level_o   (),
        .rise_o    (lfosc_rise)
    );
    edge_sync u_gate_pin (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .clk_en_i  (clk_en_i),
        .pin_i     (gate_input_pin_i),
        .level_o   (gate_pin_lvl),
        .rise_o    ()
    );

    // Register write decode
    assign wr_wctl   = wr_i && (addr_i == OFS_WIDE_CTRL);
    assign wr_gctl   = wr_i && (addr_i == OFS_GATE_CTRL);
    assign wr_low    = wr_i && (addr_i == OFS_WIDE_LOW);
    assign wr_high   = wr_i && (addr_i == OFS_WIDE_HIGH);
    assign wr_pcnt   = wr_i && (addr_i == OFS_PERIOD_CNT);
    assign wr_plim   = wr_i && (addr_i == OFS_PERIOD_LIM);
    assign wr_pctl   = wr_i && (addr_i == OFS_PERIOD_CTRL);
    assign wr_flags  = wr_i && (addr_i == OFS_FLAGS);
    assign wr_irq_en = wr_i && (addr_i == OFS_IRQ_EN);

    // Control fields
    assign wsrc     = wide_src_t'(wctl_q[WC_CS_HI:WC_CS_LO]);
    assign gsrc_sel = gate_src_t'(gctl_q[GC_SS_HI:GC_SS_LO]);
    assign wide_run = wctl_q[WC_RUN];

    // Instruction clock is every fourth system clock
    assign instr_tick = (quarter_q == QUARTER_LAST);

    // External edge: oscillator or pin, then sync or bypass path
    assign ext_edge = wctl_q[WC_OSCEN] ? osc_rise : pin_clk_rise; // RULE2
    assign ext_tick = wctl_q[WC_BYPASS] ? ext_edge : ext_resync_q; // RULE4

    // Count clock select
    always_comb
    begin
        case (wsrc) // RULE1
            SRC_INSTR:    src_tick = instr_tick;
            SRC_SYSTEM:   src_tick = 1'b1;
            SRC_EXTERNAL: src_tick = ext_tick;
            SRC_LFOSC:    src_tick = lfosc_rise;
            default:      src_tick = 1'b0;
        endcase
    end

    // Wide prescaler ratio
    always_comb
    begin
        case (wctl_q[WC_PS_HI:WC_PS_LO]) // RULE3
            2'b00:   wide_pre.limit = WPS_DIV1;
            2'b01:   wide_pre.limit = WPS_DIV2;
            2'b10:   wide_pre.limit = WPS_DIV4;
            default: wide_pre.limit = WPS_DIV8;
        endcase
    end
    assign wide_pre.tick  = src_tick && wide_run;
    assign wide_pre.clear = !wide_run;
    assign wide_tick      = wide_pre.pulse;

    tick_divider #(.W(3)) u_wide_pre (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .clk_en_i  (clk_en_i),
        .div       (wide_pre.divider)
    );

    // Gate source; internal sources are one-cycle pulses
    always_comb
    begin
        case (gsrc_sel) // RULE12
            GATE_PIN:   gate_src = gate_pin_lvl;
            GATE_OVF8:  gate_src = overflow8_pulse_i; // RULE25
            GATE_MATCH: gate_src = match; // RULE25
            default:    gate_src = 1'b0;
        endcase
    end

    // Toggle mode routes the source through tff_q
    assign gate_sig    = gctl_q[GC_TOGGLE] ? tff_q : gate_src; // RULE8
    assign gate_active = gctl_q[GC_POL] ? gate_sig : !gate_sig; // RULE7

    // Single pulse passes gate only in armed window
    assign gate_val = gctl_q[GC_SPM] ? ((sp_q == SP_OPEN) && gate_active) // RULE9
                                     : gate_active;
    assign sp_trail = (sp_q == SP_OPEN) && !gate_active;

    // Gate enable only counts while running
    assign count_en = wide_run && (!gctl_q[GC_ENABLE] || gate_val); // RULE6

    // Toggle flip-flop, held clear when toggle off or timer stopped
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            tff_q       <= 1'b0;
            gsrc_prev_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            gsrc_prev_q <= gate_src;
            if (!gctl_q[GC_TOGGLE] || !wide_run) // RULE5 RULE8
                tff_q <= 1'b0;
            else if (gate_src && !gsrc_prev_q)
                tff_q <= !tff_q; // RULE8
        end
    end

    // Single-pulse window: wait leading edge, close on trailing edge
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sp_q        <= SP_IDLE;
            gact_prev_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            gact_prev_q <= gate_active;
            case (sp_q) // RULE23
                SP_IDLE:
                    if (armed_q && gctl_q[GC_SPM])
                        sp_q <= SP_WAIT_LEAD;
                SP_WAIT_LEAD:
                    if (!armed_q || !gctl_q[GC_SPM])
                        sp_q <= SP_IDLE;
                    else if (gate_active && !gact_prev_q)
                        sp_q <= SP_OPEN;
                SP_OPEN:
                    if (sp_trail || !armed_q || !gctl_q[GC_SPM])
                        sp_q <= SP_IDLE;
                default:
                    sp_q <= SP_IDLE;
            endcase
        end
    end

    // Armed bit: software sets, trailing edge clears; the set wins
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            armed_q <= 1'b0;
        else if (clk_en_i)
        begin
            if (wr_gctl)
                armed_q <= wdata_i[GC_ARMED]; // RULE10
            else if (sp_trail)
                armed_q <= 1'b0; // RULE10 RULE23
        end
    end

    // Gate value and its falling-edge event flag
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            gval_q <= 1'b0;
            gevt_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            gval_q <= gate_val; // RULE11
            if (gval_q && !gate_val) // RULE24
                gevt_q <= 1'b1;
            else if (wr_flags && wdata_i[FL_GATE_EVT])
                gevt_q <= 1'b0;
        end
    end

    // Wide count: register writes take precedence over counting
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            wide_q <= RST_WIDE;
        else if (clk_en_i)
        begin
            if (wr_low)
                wide_q[7:0] <= wdata_i;
            else if (wr_high)
                wide_q[15:8] <= wdata_i;
            else if (wide_tick && count_en)
                wide_q <= wide_q + 16'h0001; // RULE26
        end
    end

    // Overflow flag on rollover; set beats a same-cycle clear
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            wovf_q <= 1'b0;
        else if (clk_en_i)
        begin
            if (!wr_low && !wr_high && wide_tick && count_en && (&wide_q))
                wovf_q <= 1'b1; // RULE24
            else if (wr_flags && wdata_i[FL_WIDE_OVF])
                wovf_q <= 1'b0;
        end
    end

    // Synchronised path costs one extra cycle of latency
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ext_resync_q <= 1'b0;
            quarter_q    <= 2'h0;
        end
        else if (clk_en_i)
        begin
            ext_resync_q <= ext_edge;
            quarter_q    <= quarter_q + 2'h1;
        end
    end

    // Control registers
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wctl_q   <= RST_BYTE;
            gctl_q   <= RST_BYTE;
            pctl_q   <= RST_BYTE;
            plim_q   <= RST_PERIOD_LIM; // RULE16
            irq_en_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            if (wr_wctl)
                wctl_q <= wdata_i & WIDE_CTRL_MASK;
            if (wr_gctl)
                gctl_q <= wdata_i & GATE_CTRL_MASK;
            if (wr_pctl)
                pctl_q <= wdata_i & PERIOD_CTRL_MASK; // RULE22
            if (wr_plim)
                plim_q <= wdata_i; // RULE16
            if (wr_irq_en)
                irq_en_q <= wdata_i[FL_PERIOD];
        end
    end

    // Period prescaler runs on the instruction clock only
    always_comb
    begin
        case (pctl_q[PC_PRE_HI:PC_PRE_LO]) // RULE14
            2'b00:   per_pre.limit = PPS_DIV1;
            2'b01:   per_pre.limit = PPS_DIV4;
            2'b10:   per_pre.limit = PPS_DIV16;
            default: per_pre.limit = PPS_DIV64;
        endcase
    end
    assign per_pre.tick  = instr_tick && pctl_q[PC_RUN] && !sleep_i; // RULE13 RULE21
    assign per_pre.clear = wr_pcnt || wr_pctl; // RULE17
    assign period_tick   = per_pre.pulse;

    tick_divider #(.W(6)) u_per_pre (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .clk_en_i  (clk_en_i),
        .div       (per_pre.divider)
    );

    // Match on an incrementing tick with count equal to limit
    assign match          = period_tick && (pcnt_q == plim_q) && !wr_pcnt; // RULE15
    assign period_match_o = match; // RULE20

    // Postscaler counts matches, ratio 1:1 to 1:16
    assign per_post.limit = pctl_q[PC_POST_HI:PC_POST_LO]; // RULE19
    assign per_post.tick  = match; // RULE15
    assign per_post.clear = wr_pcnt || wr_pctl; // RULE17

    tick_divider #(.W(4)) u_per_post (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .clk_en_i  (clk_en_i),
        .div       (per_post.divider)
    );

    // Period count; a control write leaves it alone
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            pcnt_q <= RST_BYTE; // RULE16
        else if (clk_en_i)
        begin
            if (wr_pcnt) // RULE18
                pcnt_q <= wdata_i;
            else if (match)
                pcnt_q <= RST_BYTE; // RULE15
            else if (period_tick)
                pcnt_q <= pcnt_q + 8'h01; // RULE13
        end
    end

    // Period flag from postscaler; set beats a same-cycle clear
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            pflag_q <= 1'b0;
        else if (clk_en_i)
        begin
            if (per_post.pulse)
                pflag_q <= 1'b1; // RULE19
            else if (wr_flags && wdata_i[FL_PERIOD])
                pflag_q <= 1'b0;
        end
    end

    // Read data registered, valid the cycle after the strobe
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rdata_q <= RST_BYTE;
        else if (clk_en_i)
        begin
            rdata_q <= RST_BYTE;
            if (rd_i)
            begin
                case (addr_i)
                    OFS_WIDE_CTRL:   rdata_q <= wctl_q;
                    OFS_GATE_CTRL:   rdata_q <= {gctl_q[7:4], armed_q, gval_q,
                                                 gctl_q[1:0]}; // RULE11
                    OFS_WIDE_LOW:    rdata_q <= wide_q[7:0];
                    OFS_WIDE_HIGH:   rdata_q <= wide_q[15:8];
                    OFS_PERIOD_CNT:  rdata_q <= pcnt_q;
                    OFS_PERIOD_LIM:  rdata_q <= plim_q;
                    OFS_PERIOD_CTRL: rdata_q <= pctl_q;
                    OFS_FLAGS:       rdata_q <= {gevt_q, 5'h00, pflag_q, wovf_q};
                    OFS_IRQ_EN:      rdata_q <= {6'h00, irq_en_q, 1'b0};
                    default:         rdata_q <= RST_BYTE;
                endcase
            end
        end
    end

    // Outputs
    assign rdata_o              = rdata_q;
    assign wide_overflow_flag_o = wovf_q;
    assign gate_event_flag_o    = gevt_q;
    assign period_match_flag_o  = pflag_q;
    assign period_irq_req_o     = pflag_q && irq_en_q; // RULE19
endmodule
`default_nettype wire

//--- testbench/gated_timer_props.sv
// Checker on the gated timer top ports.
// Assumes the bind below; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module gated_timer_props
    import timer_pkg::*;
(
    input wire logic              clk_sys_i,
    input wire logic              nrst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic              wr_i,
    input wire logic              rd_i,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic              period_match_o,
    input wire logic              wide_overflow_flag_o,
    input wire logic              gate_event_flag_o,
    input wire logic              period_match_flag_o,
    input wire logic              period_irq_req_o
);
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);
    // Bits a software write would clear
    logic [7:0] clr;
    assign clr = (wr_i && addr_i == OFS_FLAGS) ? wdata_i : 8'h00;
    property p_rd_quiet;
        !rd_i |=> rdata_o == 8'h00;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read slot");
    property p_irq;
        period_irq_req_o |-> period_match_flag_o;
    endproperty
    a_irq: assert property (p_irq) else $error("request without flag");
    property p_flag_cause;
        $rose(period_match_flag_o) |-> $past(period_match_o);
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flag without match");
    // Matches only on instruction ticks, so never closer than four cycles
    property p_spacing;
        period_match_o |=> !period_match_o [*3];
    endproperty
    a_spacing: assert property (p_spacing) else $error("matches too close");
    property p_pflag_hold;
        period_match_flag_o && !clr[FL_PERIOD] |=> period_match_flag_o;
    endproperty
    a_pflag_hold: assert property (p_pflag_hold) else $error("period flag lost");
    property p_pflag_clr;
        clr[FL_PERIOD] && !period_match_o |=> !period_match_flag_o;
    endproperty
    a_pflag_clr: assert property (p_pflag_clr) else $error("period flag not cleared");
    property p_ovf_hold;
        wide_overflow_flag_o && !clr[FL_WIDE_OVF] |=> wide_overflow_flag_o;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag lost");
    property p_gev_hold;
        gate_event_flag_o && !clr[FL_GATE_EVT] |=> gate_event_flag_o;
    endproperty
    a_gev_hold: assert property (p_gev_hold) else $error("gate event flag lost");
endmodule
bind gated_timer gated_timer_props chk (.clk_sys_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .period_match_o, .wide_overflow_flag_o, .gate_event_flag_o,
    .period_match_flag_o, .period_irq_req_o);
`default_nettype wire

//--- testbench/gated_timer_tb_top.sv
// Bench for the gated timer: register calls with expected values.
// Assumes the checker binds itself; oscillator pins held low.
`timescale 1ns/10ps
`default_nettype none
module gated_timer_tb_top
    import timer_pkg::*;
;
    logic       clk_sys_i = 1'b0;
    logic       nrst_i    = 1'b0;
    logic       sleep_i   = 1'b0;
    logic       wr_i      = 1'b0;
    logic       rd_i      = 1'b0;
    logic       gate_pin  = 1'b0;
    logic [3:0] addr_i    = 4'h0;
    logic [7:0] wdata_i   = 8'h00;
    logic [7:0] rdata_o;
    wire  [2:0] ev;
    logic       pflag;
    logic       irq;
    int         err_count = 0;
    int         comparisons = 0;
    int         n = 0;
    gated_timer dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .clk_en_i(1'b1), .sleep_i(sleep_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .wide_ext_clock_pin_i(1'b0), .secondary_osc_in_i(1'b0), .low_freq_internal_osc_i(1'b0),
        .gate_input_pin_i(gate_pin), .overflow8_pulse_i(1'b0), .period_match_o(ev[0]),
        .wide_overflow_flag_o(ev[1]), .gate_event_flag_o(ev[2]),
        .period_match_flag_o(pflag), .period_irq_req_o(irq));
    initial forever #20 clk_sys_i = ~clk_sys_i;
    task automatic close_out;
        if (err_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
        comparisons++;
        if (s !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Gap cycle first, so no strobe is driven twice in one step
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, logic [7:0] e);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 chk("rdata", e, rdata_o);
    endtask
    // Bounded wait on ev[b]: match, overflow, gate event
    task automatic wt(int b, int lim);
        repeat (lim)
        begin
            @(posedge clk_sys_i);
            #1;
            if (ev[b] === 1'b1)
                return;
        end
        chk("event", 8'h01, 8'h00);
        close_out();
    endtask
    initial
    begin
        repeat (12) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        rd(OFS_PERIOD_LIM, 8'hFF);
        rd(OFS_PERIOD_CNT, 8'h00);
        rd(4'hF, 8'h00);
        wr(OFS_WIDE_CTRL, 8'hFF);
        rd(OFS_WIDE_CTRL, 8'hFD);
        wr(OFS_PERIOD_CTRL, 8'hFF);
        rd(OFS_PERIOD_CTRL, 8'h7F);
        wr(OFS_PERIOD_LIM, 8'h03);
        wr(OFS_FLAGS, 8'hFF);
        wr(OFS_PERIOD_CTRL, 8'h14);
        // Third match raises flag, postscale 1:3
        repeat (200)
        begin
            @(posedge clk_sys_i);
            #1;
            if (ev[0] === 1'b1)
                n++;
            if (pflag === 1'b1)
                break;
        end
        chk("post", 8'h03, n[7:0]);
        chk("irq", 8'h00, {7'h00, irq});
        wr(OFS_IRQ_EN, 8'h02);
        #1 chk("irq", 8'h01, {7'h00, irq});
        wt(0, 40);
        rd(OFS_PERIOD_CNT, 8'h00);
        wr(OFS_PERIOD_CTRL, 8'h00);
        wr(OFS_PERIOD_CNT, 8'h02);
        wr(OFS_PERIOD_CTRL, 8'h00);
        rd(OFS_PERIOD_CNT, 8'h02);
        sleep_i <= 1'b1;
        wr(OFS_PERIOD_CTRL, 8'h04);
        repeat (20) @(posedge clk_sys_i);
        rd(OFS_PERIOD_CNT, 8'h02);
        sleep_i <= 1'b0;
        wr(OFS_WIDE_CTRL, 8'h00);
        wr(OFS_WIDE_LOW, 8'hFE);
        wr(OFS_WIDE_HIGH, 8'hFF);
        wr(OFS_WIDE_CTRL, 8'h41);
        wt(1, 4);
        wr(OFS_WIDE_CTRL, 8'h00);
        wr(OFS_WIDE_LOW, 8'h10);
        wr(OFS_GATE_CTRL, 8'hC0);
        wr(OFS_WIDE_CTRL, 8'h41);
        repeat (10) @(posedge clk_sys_i);
        wr(OFS_WIDE_CTRL, 8'h00);
        rd(OFS_WIDE_LOW, 8'h10);
        gate_pin <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        rd(OFS_GATE_CTRL, 8'hC4);
        wr(OFS_FLAGS, 8'h80);
        gate_pin <= 1'b0;
        wt(2, 8);
        close_out();
    end
endmodule
`default_nettype wire
